/* File: bpt_pkg.sv */
package bpt_pkg;

  localparam int unsigned BPT_CNT_W      = 16;
  localparam int unsigned BPT_ADDR_W     = 8;
  localparam int unsigned BPT_PRESC_W    = 6;

  // Byte offsets on the register bus
  localparam logic [7:0]  BPT_OFF_STATUS = 8'h00;
  localparam logic [7:0]  BPT_OFF_COUNT  = 8'h04;
  localparam logic [7:0]  BPT_OFF_MODULO = 8'h08;
  localparam logic [7:0]  BPT_OFF_CH0SC  = 8'h0c;
  localparam logic [7:0]  BPT_OFF_CH0CMP = 8'h10;
  localparam logic [7:0]  BPT_OFF_CH1SC  = 8'h14;
  localparam logic [7:0]  BPT_OFF_CH1CMP = 8'h18;
  localparam logic [7:0]  BPT_OFF_PINIO  = 8'h1c;

  // Timer status and control fields
  localparam int unsigned BPT_SC_FLAG    = 7;
  localparam int unsigned BPT_SC_IRQEN   = 6;
  localparam int unsigned BPT_SC_HALT    = 5;
  localparam int unsigned BPT_SC_CLEAR   = 4;
  localparam int unsigned BPT_SC_DIV_LSB = 0;

  // Channel status and control fields
  localparam int unsigned BPT_CH_FLAG    = 7;
  localparam int unsigned BPT_CH_IRQEN   = 6;
  localparam int unsigned BPT_CH_LINK    = 5;
  localparam int unsigned BPT_CH_SINGLE  = 4;
  localparam int unsigned BPT_CH_ELS_LSB = 2;
  localparam int unsigned BPT_CH_TOG     = 1;
  localparam int unsigned BPT_CH_MAX     = 0;

  // External clock pin port control fields
  localparam int unsigned BPT_IO_DIR     = 0;
  localparam int unsigned BPT_IO_DATA    = 1;

  // Reset values
  localparam logic        BPT_HALT_RST   = 1'b1;
  localparam logic [2:0]  BPT_DIV_RST    = 3'h0;
  localparam logic [15:0] BPT_MOD_RST    = 16'hffff;
  localparam logic [15:0] BPT_CMP_RST    = 16'h0000;

  // Clock select code of the external pin
  localparam logic [2:0]  BPT_DIV_EXT    = 3'h7;

  // Edge and level select codes
  localparam logic [1:0]  BPT_ELS_NONE   = 2'h0;
  localparam logic [1:0]  BPT_ELS_TOGGLE = 2'h1;
  localparam logic [1:0]  BPT_ELS_CLEAR  = 2'h2;
  localparam logic [1:0]  BPT_ELS_SET    = 2'h3;

endpackage : bpt_pkg

/* File: bpt_chan.sv */
`timescale 1ns/10ps
module bpt_chan import bpt_pkg::*; #(
  parameter int unsigned CNT_W = BPT_CNT_W
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst,
  // Channel configuration
  input  wire logic             enable,
  input  wire logic             link,
  input  wire logic             single,
  input  wire logic [1:0]       els,
  input  wire logic             tog,
  input  wire logic             max_req,
  input  wire logic [CNT_W-1:0] cmp,
  // Counter timing
  input  wire logic [CNT_W-1:0] cnt,
  input  wire logic             tick,
  input  wire logic             ovf,
  input  wire logic             halt,
  // Pin side
  input  wire logic             pin_in,
  output logic                  pin_out,
  output logic                  pin_oe,
  output logic                  pin_own,
  // Events to the register file
  output logic                  evt,
  output logic                  cap
);

  typedef struct packed {
    logic [2:0] sync;
    logic       out;
    logic       oe;
    logic       own;
    logic       max_eff;
  } bpt_chan_s;

  bpt_chan_s s;
  bpt_chan_s next_s;
  logic      in_cap;
  logic      out_cmp;
  logic      rise;
  logic      fall;
  logic      match;

  assign in_cap  = enable & ~link & ~single & (els != BPT_ELS_NONE);
  assign out_cmp = enable & (link | single) & (els != BPT_ELS_NONE);
  assign rise    = s.sync[1] & ~s.sync[2];
  assign fall    = ~s.sync[1] & s.sync[2];
  assign cap     = in_cap & ~halt & ((els[0] & rise) | (els[1] & fall));
  assign match   = out_cmp & tick & (cnt == cmp);
  assign evt     = cap | match;
  assign pin_out = s.out;
  assign pin_oe  = s.oe;
  assign pin_own = s.own;

  always_comb begin
    next_s      = s;
    next_s.sync = {s.sync[1:0], pin_in};
    next_s.oe   = out_cmp;
    next_s.own  = enable & (els != BPT_ELS_NONE);
    if (ovf) begin
      next_s.max_eff = max_req;
    end
    if (enable && els == BPT_ELS_NONE) begin
      next_s.out = ~single;
    end else if (out_cmp) begin
      if (ovf && tog) begin
        case (els)
          BPT_ELS_CLEAR:  next_s.out = 1'b1;
          BPT_ELS_SET:    next_s.out = max_req;
          default:        next_s.out = max_req | ~s.out;
        endcase
        if (max_req) begin
          next_s.out = 1'b1;
        end
      end else if (match && !(s.max_eff && tog)) begin
        case (els)
          BPT_ELS_TOGGLE: next_s.out = ~s.out;
          BPT_ELS_CLEAR:  next_s.out = 1'b0;
          BPT_ELS_SET:    next_s.out = 1'b1;
          default:        next_s.out = s.out;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

endmodule : bpt_chan

/* File: bpt_timer.sv */
`timescale 1ns/10ps
module bpt_timer import bpt_pkg::*; #(
  parameter int unsigned CNT_W   = BPT_CNT_W,
  parameter int unsigned ADDR_W  = BPT_ADDR_W,
  parameter int unsigned PRESC_W = BPT_PRESC_W
) (
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst,
  // APB slave
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Processor state
  input  wire logic              wait_mode,
  // Interrupt requests
  output logic                   irq_wrap,
  output logic      [1:0]        irq_chan,
  output logic                   wake_req,
  // External clock pin
  input  wire logic              ext_clk_in,
  output logic                   ext_clk_out,
  output logic                   ext_clk_oe,
  // Channel pins
  input  wire logic [1:0]        chan_pin_in,
  output logic      [1:0]        chan_pin_out,
  output logic      [1:0]        chan_pin_oe,
  output logic      [1:0]        chan_pin_own
);

  typedef struct packed {
    logic                  wrap_flag;
    logic                  wrap_arm;
    logic                  wrap_irq_enable;
    logic                  counter_halt;
    logic [2:0]            clock_divide_select;
    logic [PRESC_W-1:0]    presc;
    logic [CNT_W-1:0]      cnt;
    logic [CNT_W-1:0]      modv;
    logic [1:0]            ch_flag;
    logic [1:0]            ch_arm;
    logic [1:0]            ch_irq_enable;
    logic                  pair_link_select;
    logic [1:0]            ch_single;
    logic [1:0][1:0]       ch_els;
    logic [1:0]            ch_tog;
    logic [1:0]            ch_max;
    logic [1:0][CNT_W-1:0] cmp;
    logic                  act_sel;
    logic                  pend_sel;
    logic                  io_dir;
    logic                  io_data;
    logic [2:0]            ext_sync;
    logic                  pready;
    logic                  pslverr;
    logic [31:0]           prdata;
    logic                  irq_wrap;
    logic [1:0]            irq_chan;
    logic                  wake_req;
    logic                  ext_oe;
    logic                  ext_out;
  } bpt_timer_s;

  bpt_timer_s       s;
  bpt_timer_s       next_s;
  logic             ext_sel;
  logic             ext_rise;
  logic [6:0]       div_one;
  logic [5:0]       div_mask;
  logic             tick;
  logic             ovf;
  logic             acc;
  logic             wr;
  logic             rd;
  logic             clear_req;
  logic [1:0]       ch_evt;
  logic [1:0]       ch_cap;
  logic [1:0]       ch_en;
  logic [CNT_W-1:0] cmp0_eff;
  logic [31:0]      rdata;
  logic             known;

  assign ext_sel   = s.clock_divide_select == BPT_DIV_EXT;
  assign ext_rise  = s.ext_sync[1] & ~s.ext_sync[2];
  assign div_one   = 7'h01 << s.clock_divide_select;
  assign div_mask  = 6'(div_one - 7'h01);
  assign tick      = ~s.counter_halt & (ext_sel ? ext_rise
                                                : ((s.presc & div_mask) == div_mask));
  assign ovf       = tick & (s.cnt == s.modv);
  assign acc       = psel & penable & s.pready;
  assign wr        = acc & pwrite & ~wait_mode;
  assign rd        = acc & ~pwrite & ~wait_mode;
  assign clear_req = wr && paddr == BPT_OFF_STATUS && pwdata[BPT_SC_CLEAR];
  assign ch_en     = {~s.pair_link_select, 1'b1};
  assign cmp0_eff  = (s.pair_link_select && s.act_sel) ? s.cmp[1] : s.cmp[0];

  // Register read mux
  always_comb begin
    rdata = 32'h0000_0000;
    known = 1'b1;
    case (paddr)
      BPT_OFF_STATUS: begin
        rdata[BPT_SC_FLAG]                  = s.wrap_flag;
        rdata[BPT_SC_IRQEN]                 = s.wrap_irq_enable;
        rdata[BPT_SC_HALT]                  = s.counter_halt;
        rdata[BPT_SC_DIV_LSB+2:BPT_SC_DIV_LSB] = s.clock_divide_select;
      end
      BPT_OFF_COUNT:  rdata[CNT_W-1:0] = s.cnt;
      BPT_OFF_MODULO: rdata[CNT_W-1:0] = s.modv;
      BPT_OFF_CH0SC: begin
        rdata[BPT_CH_FLAG]                      = s.ch_flag[0];
        rdata[BPT_CH_IRQEN]                     = s.ch_irq_enable[0];
        rdata[BPT_CH_LINK]                      = s.pair_link_select;
        rdata[BPT_CH_SINGLE]                    = s.ch_single[0];
        rdata[BPT_CH_ELS_LSB+1:BPT_CH_ELS_LSB]  = s.ch_els[0];
        rdata[BPT_CH_TOG]                       = s.ch_tog[0];
        rdata[BPT_CH_MAX]                       = s.ch_max[0];
      end
      BPT_OFF_CH1SC: begin
        if (!s.pair_link_select) begin
          rdata[BPT_CH_FLAG]                     = s.ch_flag[1];
          rdata[BPT_CH_IRQEN]                    = s.ch_irq_enable[1];
          rdata[BPT_CH_SINGLE]                   = s.ch_single[1];
          rdata[BPT_CH_ELS_LSB+1:BPT_CH_ELS_LSB] = s.ch_els[1];
          rdata[BPT_CH_TOG]                      = s.ch_tog[1];
          rdata[BPT_CH_MAX]                      = s.ch_max[1];
        end
      end
      BPT_OFF_CH0CMP: rdata[CNT_W-1:0] = s.cmp[0];
      BPT_OFF_CH1CMP: rdata[CNT_W-1:0] = s.cmp[1];
      BPT_OFF_PINIO: begin
        rdata[BPT_IO_DIR]  = s.io_dir;
        rdata[BPT_IO_DATA] = s.io_data;
      end
      default:        known = 1'b0;
    endcase
  end

  always_comb begin
    next_s          = s;
    next_s.ext_sync = {s.ext_sync[1:0], ext_clk_in};

    // Bus handshake: one wait state, answer prepared from the stable address
    next_s.pready  = psel & penable & ~s.pready;
    next_s.pslverr = psel & penable & ~s.pready & (~known | wait_mode);
    next_s.prdata  = (psel & penable & ~s.pready & ~pwrite & known & ~wait_mode) ? rdata : 32'h0000_0000;

    // Prescaler and counter
    if (!s.counter_halt) begin
      next_s.presc = s.presc + 1'b1;
    end
    if (tick) begin
      next_s.cnt = ovf ? '0 : s.cnt + 1'b1;
    end
    if (clear_req) begin
      next_s.presc = '0;
      next_s.cnt   = '0;
    end

    // Read half of the flag clearing sequences
    if (rd && paddr == BPT_OFF_STATUS && s.wrap_flag) begin
      next_s.wrap_arm = 1'b1;
    end
    for (int i = 0; i < 2; i++) begin
      if (rd && paddr == (i == 0 ? BPT_OFF_CH0SC : BPT_OFF_CH1SC) && s.ch_flag[i]) begin
        next_s.ch_arm[i] = 1'b1;
      end
    end

    // Register writes
    if (wr) begin
      case (paddr)
        BPT_OFF_STATUS: begin
          if (!pwdata[BPT_SC_FLAG] && s.wrap_arm) begin
            next_s.wrap_flag = 1'b0;
          end
          next_s.wrap_arm            = 1'b0;
          next_s.wrap_irq_enable     = pwdata[BPT_SC_IRQEN];
          next_s.counter_halt        = pwdata[BPT_SC_HALT];
          next_s.clock_divide_select = pwdata[BPT_SC_DIV_LSB+2:BPT_SC_DIV_LSB];
        end
        BPT_OFF_MODULO: next_s.modv = pwdata[CNT_W-1:0];
        BPT_OFF_CH0SC, BPT_OFF_CH1SC: begin
          for (int i = 0; i < 2; i++) begin
            if (paddr == (i == 0 ? BPT_OFF_CH0SC : BPT_OFF_CH1SC) && ch_en[i]) begin
              if (!pwdata[BPT_CH_FLAG] && s.ch_arm[i]) begin
                next_s.ch_flag[i] = 1'b0;
              end
              next_s.ch_arm[i]        = 1'b0;
              next_s.ch_irq_enable[i] = pwdata[BPT_CH_IRQEN];
              next_s.ch_single[i]     = pwdata[BPT_CH_SINGLE];
              next_s.ch_els[i]        = pwdata[BPT_CH_ELS_LSB+1:BPT_CH_ELS_LSB];
              next_s.ch_tog[i]        = pwdata[BPT_CH_TOG];
              next_s.ch_max[i]        = pwdata[BPT_CH_MAX];
            end
          end
          if (paddr == BPT_OFF_CH0SC) begin
            next_s.pair_link_select = pwdata[BPT_CH_LINK];
            if (pwdata[BPT_CH_LINK] && !s.pair_link_select) begin
              next_s.act_sel  = 1'b0;
              next_s.pend_sel = 1'b0;
            end
          end
        end
        BPT_OFF_CH0CMP: begin
          next_s.cmp[0]   = pwdata[CNT_W-1:0];
          next_s.pend_sel = 1'b0;
        end
        BPT_OFF_CH1CMP: begin
          next_s.cmp[1]   = pwdata[CNT_W-1:0];
          next_s.pend_sel = 1'b1;
        end
        BPT_OFF_PINIO: begin
          next_s.io_dir  = pwdata[BPT_IO_DIR];
          next_s.io_data = pwdata[BPT_IO_DATA];
        end
        default: begin
        end
      endcase
    end

    // Buffered pair hand-over at the period boundary
    if (ovf && s.pair_link_select) begin
      next_s.act_sel = next_s.pend_sel;
    end

    // Hardware events set flags; a set wins over a clear in the same cycle
    if (ovf) begin
      next_s.wrap_flag = 1'b1;
      next_s.wrap_arm  = 1'b0;
    end
    for (int i = 0; i < 2; i++) begin
      if (ch_cap[i]) begin
        next_s.cmp[i] = s.cnt;
      end
      if (ch_evt[i]) begin
        next_s.ch_flag[i] = 1'b1;
        next_s.ch_arm[i]  = 1'b0;
      end
    end

    // Interrupt requests and wake-up
    next_s.irq_wrap = next_s.wrap_flag & next_s.wrap_irq_enable;
    next_s.irq_chan = next_s.ch_flag & next_s.ch_irq_enable & ch_en;
    next_s.wake_req = next_s.irq_wrap | (|next_s.irq_chan);

    // External clock pin port use
    next_s.ext_oe  = next_s.io_dir & (next_s.clock_divide_select != BPT_DIV_EXT);
    next_s.ext_out = next_s.io_data;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s                     <= '0;
      s.counter_halt        <= BPT_HALT_RST;
      s.clock_divide_select <= BPT_DIV_RST;
      s.modv                <= BPT_MOD_RST;
      s.cmp                 <= {BPT_CMP_RST, BPT_CMP_RST};
    end else begin
      s <= next_s;
    end
  end

  // Channel 0 carries the buffered output when linked
  bpt_chan #(
    .CNT_W (CNT_W)
  ) u_chan0 (
    .ref_clk (ref_clk),
    .rst     (rst),
    .enable  (ch_en[0]),
    .link    (s.pair_link_select),
    .single  (s.ch_single[0]),
    .els     (s.ch_els[0]),
    .tog     (s.ch_tog[0]),
    .max_req (s.ch_max[0]),
    .cmp     (cmp0_eff),
    .cnt     (s.cnt),
    .tick    (tick),
    .ovf     (ovf),
    .halt    (s.counter_halt),
    .pin_in  (chan_pin_in[0]),
    .pin_out (chan_pin_out[0]),
    .pin_oe  (chan_pin_oe[0]),
    .pin_own (chan_pin_own[0]),
    .evt     (ch_evt[0]),
    .cap     (ch_cap[0])
  );

  // Channel 1 is released to port use when linked
  bpt_chan #(
    .CNT_W (CNT_W)
  ) u_chan1 (
    .ref_clk (ref_clk),
    .rst     (rst),
    .enable  (ch_en[1]),
    .link    (1'b0),
    .single  (s.ch_single[1]),
    .els     (s.ch_els[1]),
    .tog     (s.ch_tog[1]),
    .max_req (s.ch_max[1]),
    .cmp     (s.cmp[1]),
    .cnt     (s.cnt),
    .tick    (tick),
    .ovf     (ovf),
    .halt    (s.counter_halt),
    .pin_in  (chan_pin_in[1]),
    .pin_out (chan_pin_out[1]),
    .pin_oe  (chan_pin_oe[1]),
    .pin_own (chan_pin_own[1]),
    .evt     (ch_evt[1]),
    .cap     (ch_cap[1])
  );

  assign prdata      = s.prdata;
  assign pready      = s.pready;
  assign pslverr     = s.pslverr;
  assign irq_wrap    = s.irq_wrap;
  assign irq_chan    = s.irq_chan;
  assign wake_req    = s.wake_req;
  assign ext_clk_out = s.ext_out;
  assign ext_clk_oe  = s.ext_oe;

endmodule : bpt_timer

/* File: bpt_timer_sva.sv */
`timescale 1ns/10ps
module bpt_timer_sva import bpt_pkg::*; #(
  parameter int unsigned CNT_W = BPT_CNT_W, ADDR_W = BPT_ADDR_W, PRESC_W = BPT_PRESC_W
) (
  // Clock, reset and register bus
  input wire logic              ref_clk, rst, psel, penable, pwrite, pready, pslverr,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata, prdata,
  // Processor state, interrupts and pins
  input wire logic              wait_mode, irq_wrap, wake_req, ext_clk_in, ext_clk_out, ext_clk_oe,
  input wire logic [1:0]        irq_chan, chan_pin_in, chan_pin_out, chan_pin_oe, chan_pin_own
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  // Write transfer completing at this edge
  logic wr_done;
  assign wr_done = psel && penable && pready && pwrite;
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable;
  endsequence
  a_ready_one_wait: assert property (s_setup ##1 s_access |=> pready)
    else $error("pready late");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready too long");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr alone");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero");
  a_wait_refused: assert property (pready && wait_mode && $past(wait_mode) |-> pslverr && prdata == 32'h0)
    else $error("wait access taken");
  a_wake_any_irq: assert property (wake_req == (irq_wrap || irq_chan != 2'h0))
    else $error("wake mismatch");
  a_wrap_clear_write: assert property ($fell(irq_wrap) |-> $past(wr_done) || $past(wr_done, 2))
    else $error("wrap irq dropped");
  a_chan_clear_write: assert property ($fell(irq_chan[0]) || $fell(irq_chan[1]) |->
    $past(wr_done) || $past(wr_done, 2))
    else $error("channel irq dropped");
endmodule : bpt_timer_sva

bind bpt_timer bpt_timer_sva #(.CNT_W(CNT_W), .ADDR_W(ADDR_W), .PRESC_W(PRESC_W)) u_sva (
  .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready),
  .pslverr(pslverr), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .wait_mode(wait_mode),
  .irq_wrap(irq_wrap), .wake_req(wake_req), .ext_clk_in(ext_clk_in), .ext_clk_out(ext_clk_out),
  .ext_clk_oe(ext_clk_oe), .irq_chan(irq_chan), .chan_pin_in(chan_pin_in), .chan_pin_out(chan_pin_out),
  .chan_pin_oe(chan_pin_oe), .chan_pin_own(chan_pin_own)
);

/* File: test_bpt_timer.sv */
`timescale 1ns/10ps
module test_bpt_timer import bpt_pkg::*;;
  logic        ref_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        wait_mode = 1'b0, ext_clk_in = 1'b0, rerr, pready, pslverr, irq_wrap;
  logic        wake_req, ext_clk_out, ext_clk_oe;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdat, hc, c0;
  logic [1:0]  chan_pin_in = 2'h0, irq_chan, chan_pin_out, chan_pin_oe, chan_pin_own;
  int          fail_count = 0, comparisons = 0, cycles = 0;
  bpt_timer uut (
    .ref_clk(ref_clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .wait_mode(wait_mode),
    .irq_wrap(irq_wrap), .irq_chan(irq_chan), .wake_req(wake_req), .ext_clk_in(ext_clk_in),
    .ext_clk_out(ext_clk_out), .ext_clk_oe(ext_clk_oe), .chan_pin_in(chan_pin_in),
    .chan_pin_out(chan_pin_out), .chan_pin_oe(chan_pin_oe), .chan_pin_own(chan_pin_own)
  );
  always #12.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      fail_count++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    if (fail_count == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic chkr(input string n, input int lo, input int hi, input logic [31:0] g);
    comparisons++;
    if ($isunknown(g) || g < lo || g > hi) begin
      fail_count++;
      $display("[ERR] %s expected %0d..%0d seen %0d", n, lo, hi, g);
    end
  endtask : chkr
  // One APB transfer, then one idle cycle
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    while (pready !== 1'b1)
      @(posedge ref_clk);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask : apb
  // High cycles of channel 0 output after settling
  task automatic hi(input int n);
    repeat (32) @(posedge ref_clk);
    hc = 32'h0;
    repeat (n) begin
      @(posedge ref_clk);
      hc = hc + chan_pin_out[0];
    end
  endtask : hi
  task automatic t_reset();
    apb(BPT_OFF_STATUS, 1'b0, 32'h0);
    chk("status", 32'h20, rdat);
    apb(BPT_OFF_COUNT, 1'b0, 32'h0);
    chk("count", 32'h0, rdat);
    apb(8'h20, 1'b0, 32'h0);
    chk("unmapped", 32'h1, {31'h0, rerr});
    chk("preset level", 32'h3, {30'h0, chan_pin_out});
  endtask : t_reset
  task automatic t_wrap();
    apb(BPT_OFF_MODULO, 1'b1, 32'h3);
    apb(BPT_OFF_STATUS, 1'b1, 32'h40);
    repeat (8) @(posedge ref_clk);
    chk("wrap irq", 32'h1, {31'h0, irq_wrap});
    apb(BPT_OFF_STATUS, 1'b1, 32'h70);
    apb(BPT_OFF_COUNT, 1'b0, 32'h0);
    chk("halt clear", 32'h0, rdat);
    chk("no read", 32'h1, {31'h0, irq_wrap});
    apb(BPT_OFF_STATUS, 1'b0, 32'h0);
    chk("flag", 32'he0, rdat);
    apb(BPT_OFF_STATUS, 1'b1, 32'h60);
    @(posedge ref_clk);
    chk("cleared", 32'h0, {31'h0, irq_wrap});
    apb(BPT_OFF_STATUS, 1'b1, 32'he0);
    @(posedge ref_clk);
    chk("write one", 32'h0, {31'h0, irq_wrap});
    // Overflow between the read and the write, none at the write itself
    apb(BPT_OFF_MODULO, 1'b1, 32'h10);
    apb(BPT_OFF_STATUS, 1'b1, 32'h40);
    repeat (20) @(posedge ref_clk);
    apb(BPT_OFF_STATUS, 1'b0, 32'h0);
    chk("flag set", 32'hc0, rdat);
    repeat (12) @(posedge ref_clk);
    apb(BPT_OFF_STATUS, 1'b1, 32'h60);
    @(posedge ref_clk);
    chk("clear lost", 32'h1, {31'h0, irq_wrap});
  endtask : t_wrap
  task automatic t_div();
    int e;
    apb(BPT_OFF_PINIO, 1'b1, 32'h3);
    for (int k = 0; k < 8; k++) begin
      apb(BPT_OFF_STATUS, 1'b1, 32'h30);
      apb(BPT_OFF_MODULO, 1'b1, 32'hffff);
      apb(BPT_OFF_STATUS, 1'b1, 32'(k));
      apb(BPT_OFF_COUNT, 1'b0, 32'h0);
      c0 = rdat;
      e = (k == 7) ? 16 : 256 >> k;
      chk("ext oe", {31'h0, k != 7}, {31'h0, ext_clk_oe});
      if (k == 7)
        repeat (32) begin
          repeat (4) @(posedge ref_clk);
          ext_clk_in <= ~ext_clk_in;
        end
      else
        repeat (252) @(posedge ref_clk);
      apb(BPT_OFF_COUNT, 1'b0, 32'h0);
      chkr("count step", e - 1, e + 1, rdat - c0);
    end
    chk("ext data", 32'h1, {31'h0, ext_clk_out});
  endtask : t_div
  task automatic t_pwm();
    apb(BPT_OFF_STATUS, 1'b1, 32'h30);
    apb(BPT_OFF_MODULO, 1'b1, 32'hf);
    apb(BPT_OFF_CH0CMP, 1'b1, 32'h8);
    apb(BPT_OFF_CH0SC, 1'b1, 32'h1a);
    apb(BPT_OFF_STATUS, 1'b1, 32'h0);
    hi(64);
    chkr("pwm high", 32, 40, hc);
    chk("ch0 oe", 32'h1, {31'h0, chan_pin_oe[0]});
    chk("ch0 own", 32'h1, {31'h0, chan_pin_own[0]});
    apb(BPT_OFF_CH0SC, 1'b1, 32'h18);
    hi(32);
    chkr("zero duty", 0, 0, hc);
    apb(BPT_OFF_CH0SC, 1'b1, 32'h1b);
    hi(32);
    chkr("full duty", 32, 32, hc);
    apb(BPT_OFF_CH0SC, 1'b1, 32'h1e);
    hi(64);
    chkr("set mode", 24, 32, hc);
  endtask : t_pwm
  task automatic t_link();
    apb(BPT_OFF_STATUS, 1'b1, 32'h30);
    apb(BPT_OFF_CH0CMP, 1'b1, 32'h4);
    apb(BPT_OFF_CH0SC, 1'b1, 32'h7a);
    apb(BPT_OFF_STATUS, 1'b1, 32'h0);
    hi(64);
    chkr("ch0 width", 16, 24, hc);
    apb(BPT_OFF_CH1CMP, 1'b1, 32'hc);
    hi(64);
    chkr("ch1 width", 48, 56, hc);
    apb(BPT_OFF_CH1SC, 1'b1, 32'h1a);
    apb(BPT_OFF_CH1SC, 1'b0, 32'h0);
    chk("ch1 control", 32'h0, rdat);
    chk("ch1 own irq", 32'h0, {30'h0, chan_pin_own[1], irq_chan[1]});
    chk("ch0 irq", 32'h1, {31'h0, irq_chan[0]});
    chk("wake", 32'h1, {31'h0, wake_req});
    apb(BPT_OFF_CH0CMP, 1'b1, 32'h2);
    hi(64);
    chkr("ch0 again", 8, 16, hc);
  endtask : t_link
  task automatic t_capture();
    apb(BPT_OFF_STATUS, 1'b1, 32'h30);
    apb(BPT_OFF_CH0SC, 1'b1, 32'h0);
    apb(BPT_OFF_CH1SC, 1'b1, 32'h4);
    for (int i = 0; i < 2; i++) begin
      apb(BPT_OFF_STATUS, 1'b1, i ? 32'h0 : 32'h20);
      chan_pin_in[1] <= 1'b1;
      repeat (4) @(posedge ref_clk);
      chan_pin_in[1] <= 1'b0;
      repeat (4) @(posedge ref_clk);
      apb(BPT_OFF_CH1SC, 1'b0, 32'h0);
      chk("capture flag", i ? 32'h84 : 32'h4, rdat);
    end
    apb(BPT_OFF_CH1SC, 1'b1, 32'h4);
    apb(BPT_OFF_CH1SC, 1'b0, 32'h0);
    chk("flag cleared", 32'h4, rdat);
    chk("ch1 pins", 32'h1, {30'h0, chan_pin_oe[1], chan_pin_own[1]});
  endtask : t_capture
  task automatic t_wait();
    wait_mode <= 1'b1;
    apb(BPT_OFF_MODULO, 1'b1, 32'h5);
    apb(BPT_OFF_STATUS, 1'b0, 32'h0);
    chk("wait refusal", 32'h1, {31'h0, rerr});
    wait_mode <= 1'b0;
    apb(BPT_OFF_MODULO, 1'b0, 32'h0);
    chk("modulo kept", 32'hf, rdat);
  endtask : t_wait
  initial begin
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    t_reset();
    t_wrap();
    t_div();
    t_pwm();
    t_link();
    t_capture();
    t_wait();
    give_verdict();
  end
endmodule : test_bpt_timer
